// File: dv/sdpdi_core_monitor.sv
// concurrent checks on the pins of the data integrity block
module sdpdi_core_monitor (
	// clock, reset and mode
	input wire logic                   clock,
	input wire logic                   rst_n,
	input wire sdpdi_pkg::sdpdi_mode_t mode,
	// command side
	input wire logic                   cs_n,
	input wire sdpdi_pkg::sdpdi_ca_t   ca,
	input wire logic                   odt,
	input wire logic                   cmd_valid,
	input wire sdpdi_pkg::sdpdi_cmd_t  cmd,
	// pins and status the block drives
	input wire sdpdi_pkg::sdpdi_term_t term,
	input wire logic                   dqs_l_t_out,
	input wire logic                   dqs_l_c_out,
	input wire logic                   dqs_oe,
	input wire logic                   alert_n_out,
	input wire logic                   alert_oe,
	input wire logic                   parity_error,
	input wire logic                   crc_error,
	input wire logic                   recovery_busy
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// a bad parity only counts outside recovery, where commands are dropped anyway
	wire logic par_bad = mode.parity_enable && ((^ca[22:1]) != ca.parity);
	wire logic take    = !cs_n && !par_bad && !recovery_busy && !parity_error;
	sequence s_crc_low;
		!alert_n_out [*6] ##1 alert_n_out;
	endsequence
	a_term_on: assert property (mode.rtt_enable && odt |=> term == 5'h1F)
		else $error("termination not switched on");
	a_term_groups: assert property (term == 5'h1F || term == 5'h00)
		else $error("termination groups differ");
	a_term_off: assert property (!mode.rtt_enable |=> term == 5'h00)
		else $error("termination on while disabled");
	a_parity_flag: assert property (!cs_n && par_bad && !recovery_busy && !parity_error |=>
		parity_error && !cmd_valid)
		else $error("parity error not flagged");
	a_act_row: assert property (take && !ca.act_n |=> cmd_valid && cmd.kind == sdpdi_pkg::CMD_ACTIVATE &&
		cmd.addr == $past({ca.ras_n_a16, ca.cas_n_a15, ca.we_n_a14, ca.a}))
		else $error("activate row address wrong");
	a_desel_ignored: assert property (cs_n |=> !cmd_valid)
		else $error("deselected command taken");
	a_crc_alert: assert property (crc_error && !recovery_busy |=> s_crc_low)
		else $error("crc alert pulse wrong");
	a_recov_alert: assert property (recovery_busy |-> !alert_n_out)
		else $error("alert released during recovery");
	a_ct_input: assert property (mode.conn_test |=> !alert_oe)
		else $error("alert driven in connectivity test");
	a_strobe_pair: assert property (dqs_l_c_out == !dqs_l_t_out)
		else $error("strobe pair not differential");
	a_strobe_beat: assert property (dqs_oe && $past(dqs_oe) |-> $changed(dqs_l_t_out))
		else $error("read strobe missed a beat");
endmodule : sdpdi_core_monitor

// File: dv/sdpdi_core_tb.sv
// self-checking bench of the pin-level data integrity block
module sdpdi_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] BASE = 16'h3C10;
	logic clock, rst_n, cs_n, odt, dm_l, dm_u, alert_in, wr_ready, ovr_clr, go, crc_on, bad, dqs;
	logic dq_oe, dmo_l, dmo_u, alert_out, alert_oe, ct_lvl, cmd_valid, wr_valid, overrun, rd_req;
	logic [15:0] dq, rd_data, dq_out;
	logic [17:0] wr_word;
	logic [3:0] vref;
	sdpdi_pkg::sdpdi_mode_t mode;
	sdpdi_pkg::sdpdi_ca_t ca;
	sdpdi_pkg::sdpdi_term_t term;
	sdpdi_pkg::sdpdi_cmd_t cmd;
	int fails, n_checks, lows, k;
	// {dm, wdbi, mask_l_n, mask_u_n, keep_u, keep_l, expected flip}
	logic [21:0] rows [5] = '{{6'b001111, 16'h0}, {6'b010111, 16'h00FF}, {6'b011011, 16'hFF00},
		{6'b100110, 16'h0}, {6'b100000, 16'h0}};
	sdpdi_core i_dut (.clock(clock), .rst_n(rst_n), .mode(mode), .cs_n(cs_n), .ca(ca), .odt(odt),
		.dq_in(dq), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_l_t_in(dqs), .dqs_l_c_in(!dqs),
		.dqs_u_t_in(dqs), .dqs_u_c_in(!dqs), .dqs_l_t_out(), .dqs_l_c_out(), .dqs_u_t_out(),
		.dqs_u_c_out(), .dqs_oe(), .dm_dbi_l_n_in(dm_l), .dm_dbi_u_n_in(dm_u),
		.dm_dbi_l_n_out(dmo_l), .dm_dbi_u_n_out(dmo_u), .dm_dbi_oe(), .term(term),
		.vref_probe_en(vref), .alert_n_in(alert_in), .alert_n_out(alert_out), .alert_oe(alert_oe),
		.ct_alert_level(ct_lvl), .cmd_valid(cmd_valid), .cmd(cmd), .wr_valid(wr_valid),
		.wr_word(wr_word), .wr_ready(wr_ready), .rd_req(rd_req), .rd_data(rd_data), .parity_error(),
		.crc_error(), .recovery_busy(), .overrun(overrun), .overrun_clr(ovr_clr));
	sdpdi_host_model i_host (.clock(clock), .rst_n(rst_n), .go(go), .crc_on(crc_on), .bad(bad),
		.base(BASE), .dqs(dqs), .dq(dq));
	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize
	// one selected command with even parity, optionally spoilt, plus the host burst start
	task automatic issue(input logic [2:0] op, input logic act_n, input logic flip, input logic g);
		logic [21:0] f;
		f = {act_n, op, 2'h1, 2'h2, 14'h1A5C};
		@(posedge clock);
		cs_n <= 1'b0;
		ca   <= {f, (^f) ^ flip};
		go   <= g;
		@(posedge clock);
		cs_n <= 1'b1;
		go   <= 1'b0;
	endtask : issue
	// write burst, then every word taken off the fifo is compared on its kept lanes
	task automatic burst(input logic [15:0] flip, input logic [1:0] keep, input int n_exp);
		logic [17:0] m;
		m = {2'b11, {8{keep[1]}}, {8{keep[0]}}};
		k = 0;
		issue(3'h4, 1'b1, 1'b0, 1'b1);
		repeat (30) begin
			@(negedge clock);
			if (wr_valid === 1'b1 && k < 8) begin
				chk(wr_word & m, {keep, (BASE + 16'h0101 * k[15:0]) ^ flip} & m);
				k++;
			end
		end
		chk(18'(k), 18'(n_exp));
		@(posedge clock);
	endtask : burst
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// an alert low is counted wherever it happens, so bursts need not watch for it
	always @(posedge clock) if (alert_out === 1'b0) lows++;
	initial begin
		repeat (6000) @(posedge clock);
		fails++;
		summarize();
	end
	initial begin
		{rst_n, odt, dm_l, dm_u, go, crc_on, bad, ovr_clr} = '0;
		{cs_n, alert_in, wr_ready} = 3'h7;
		rd_data = 16'h00FF;
		ca = '0;
		mode = '0;
		mode.parity_enable = 1'b1;
		mode.rdbi_enable = 1'b1;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		odt   <= 1'b1;
		lows = 0;
		for (int i = 0; i < 5; i++) begin
			@(posedge clock);
			{mode.dm_enable, mode.wdbi_enable, dm_l, dm_u} <= rows[i][21:18];
			mode.rtt_enable <= rows[i][18];
			{mode.crc_enable, crc_on} <= {2{i[0]}};
			burst(rows[i][15:0], rows[i][17:16], rows[i][17:16] != 2'b00 ? 8 : 0);
			chk(18'(term), rows[i][18] ? 18'h1F : 18'h0);
			$display("write row %0d done", i);
		end
		chk(18'(lows), 18'h0);
		issue(3'h5, 1'b0, 1'b0, 1'b0);
		{mode.crc_enable, crc_on, bad} <= 3'h7;
		{mode.dm_enable, dm_l, dm_u} <= 3'b011;
		@(negedge clock);
		chk({cmd_valid, cmd.addr}, 18'h35A5C);
		burst(16'h0, 2'b11, 8);
		chk(18'(lows), 18'(sdpdi_pkg::ALERT_CRC_CYC));
		{mode.crc_enable, crc_on, bad} <= 3'h0;
		lows = 0;
		issue(3'h5, 1'b1, 1'b1, 1'b0);
		issue(3'h5, 1'b0, 1'b0, 1'b0);
		@(negedge clock);
		chk(18'(cmd_valid), 18'h0);
		repeat (30) @(posedge clock);
		chk(18'(lows), 18'(sdpdi_pkg::RECOVERY_CYC));
		// alert is back high: the refused activate is retried and taken
		issue(3'h5, 1'b0, 1'b0, 1'b0);
		// fill with the far side stalled until a beat is lost, then drain to empty
		wr_ready <= 1'b0;
		@(negedge clock);
		chk(18'(cmd_valid), 18'h1);
		$display("alert tests done");
		repeat (3) begin
			issue(3'h4, 1'b1, 1'b0, 1'b1);
			repeat (10) @(posedge clock);
		end
		chk(18'(overrun), 18'h1);
		ovr_clr <= 1'b1;
		@(posedge clock);
		{ovr_clr, wr_ready} <= 2'b01;
		repeat (30) @(posedge clock);
		chk({overrun, wr_valid}, 18'h0);
		k = 0;
		issue(3'h5, 1'b1, 1'b0, 1'b0);
		@(negedge clock);
		chk(18'(rd_req), 18'h1);
		repeat (20) begin
			@(negedge clock);
			if (dq_oe === 1'b1) begin
				chk({dmo_u, dmo_l, dq_out}, 18'h1FFFF);
				k++;
			end
		end
		chk(18'(k), 18'h8);
		@(posedge clock);
		{mode.conn_test, mode.vref_monitor, alert_in} <= 3'b110;
		mode.vref_probe_sel <= 4'h9;
		repeat (6) @(posedge clock);
		chk({alert_oe, ct_lvl, vref}, 18'h9);
		{mode.conn_test, mode.rtt_enable} <= 2'b01;
		repeat (3) @(posedge clock);
		rst_n <= 1'b0;
		#1;
		chk({alert_out, 5'(term), dq_oe}, 18'h40);
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		chk(18'(term), 18'h1F);
		$display("fifo, read and reset tests done");
		summarize();
	end
endmodule : sdpdi_core_tb
bind sdpdi_core sdpdi_core_monitor i_mon (.clock(clock), .rst_n(rst_n), .mode(mode), .cs_n(cs_n),
	.ca(ca), .odt(odt), .cmd_valid(cmd_valid), .cmd(cmd), .term(term), .dqs_l_t_out(dqs_l_t_out),
	.dqs_l_c_out(dqs_l_c_out), .dqs_oe(dqs_oe), .alert_n_out(alert_n_out), .alert_oe(alert_oe),
	.parity_error(parity_error), .crc_error(crc_error), .recovery_busy(recovery_busy));

// File: dv/sdpdi_host_model.sv
// host side write driver: strobe, data beats and the trailing crc beat
module sdpdi_host_model (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// burst request
	input  wire logic        go,
	input  wire logic        crc_on,
	input  wire logic        bad,
	input  wire logic [15:0] base,
	// pins towards the memory
	output      logic        dqs,
	output      logic [15:0] dq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] n;
	// msb-first crc of one byte lane over beats 0..7
	function automatic logic [7:0] lane_crc(input logic [7:0] b);
		logic [7:0] c, d;
		c = 8'hFF;
		for (int k = 0; k < 8; k++) begin
			d = b + 8'(k);
			for (int j = 7; j >= 0; j--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[j]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction : lane_crc
	// strobe stands still between bursts; released data lines scramble so no stale beat shows
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			n   <= 4'h0;
			dqs <= 1'b0;
			dq  <= 16'h0000;
		end else if (go || (n != 4'h0 && n < (crc_on ? 4'h9 : 4'h8))) begin
			dqs <= ~dqs;
			dq  <= (n == 4'h8) ? {lane_crc(base[15:8]), lane_crc(base[7:0])} ^ {15'h0, bad}
				: base + 16'h0101 * n;
			n   <= n + 4'h1;
		end else begin
			n  <= 4'h0;
			dq <= ~dq;
		end
	end
endmodule : sdpdi_host_model

// File: rtl/sdpdi_core.sv
// pin-level command, termination, data integrity and alert logic of a sixteen-bit memory
module sdpdi_core (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	// mode register settings
	input  wire sdpdi_pkg::sdpdi_mode_t mode,
	// command, address and control pins
	input  wire logic                  cs_n,
	input  wire sdpdi_pkg::sdpdi_ca_t   ca,
	input  wire logic                  odt,
	// data pins
	input  wire logic [15:0]           dq_in,
	output      logic [15:0]           dq_out,
	output      logic                  dq_oe,
	// strobe pins, lower and upper pairs
	input  wire logic                  dqs_l_t_in,
	input  wire logic                  dqs_l_c_in,
	input  wire logic                  dqs_u_t_in,
	input  wire logic                  dqs_u_c_in,
	output      logic                  dqs_l_t_out,
	output      logic                  dqs_l_c_out,
	output      logic                  dqs_u_t_out,
	output      logic                  dqs_u_c_out,
	output      logic                  dqs_oe,
	// shared mask / inversion pins
	input  wire logic                  dm_dbi_l_n_in,
	input  wire logic                  dm_dbi_u_n_in,
	output      logic                  dm_dbi_l_n_out,
	output      logic                  dm_dbi_u_n_out,
	output      logic                  dm_dbi_oe,
	// termination and reference monitor
	output      sdpdi_pkg::sdpdi_term_t term,
	output      logic [3:0]            vref_probe_en,
	// alert pin
	input  wire logic                  alert_n_in,
	output      logic                  alert_n_out,
	output      logic                  alert_oe,
	output      logic                  ct_alert_level,
	// decoded commands
	output      logic                  cmd_valid,
	output      sdpdi_pkg::sdpdi_cmd_t  cmd,
	// write data towards the array
	output      logic                  wr_valid,
	output      logic [17:0]           wr_word,
	input  wire logic                  wr_ready,
	// read data from the array
	output      logic                  rd_req,
	input  wire logic [15:0]           rd_data,
	// status
	output      logic                  parity_error,
	output      logic                  crc_error,
	output      logic                  recovery_busy,
	output      logic                  overrun,
	input  wire logic                  overrun_clr
);
	typedef enum logic [1:0] {
		AL_IDLE,
		AL_CRC_PULSE,
		AL_RECOVERY
	} sdpdi_alert_state_t;

	sdpdi_alert_state_t        alert_state;
	logic [sdpdi_pkg::ALERT_CNT_W-1:0] alert_cnt;
	logic                      par_calc;
	logic                      par_bad;
	logic                      cmd_take;
	logic [2:0]                opcode;
	logic                      is_read;
	logic                      is_write;
	logic                      dqs_l_prev;
	logic                      dqs_u_prev;
	logic                      edge_l;
	logic                      edge_u;
	logic [7:0]                upper_hold;
	logic                      upper_mask_hold;
	logic [7:0]                upper_raw;
	logic                      upper_pin;
	logic                      wr_active;
	logic [3:0]                wr_beat;
	logic [7:0]                crc_l;
	logic [7:0]                crc_u;
	logic                      crc_beat;
	logic                      crc_bad;
	logic                      data_beat;
	logic [1:0]                keep;
	logic [15:0]               beat_data;
	logic                      fifo_in_valid;
	logic                      fifo_in_ready;
	logic                      rd_active;
	logic [3:0]                rd_beat;
	logic [7:0]                rd_crc_l;
	logic [7:0]                rd_crc_u;
	logic                      rd_inv_l;
	logic                      rd_inv_u;
	logic                      alert_sync1;
	logic                      alert_sync2;

	// one crc-8 step over a byte; shared by write check and read generation
	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ sdpdi_pkg::CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc8_step

	// read inversion pays off when most bits of the byte are zero
	function automatic logic want_invert(input logic [7:0] data);
		logic [3:0] zeros;
		zeros = '0;
		for (int i = 0; i < 8; i++) begin
			zeros = zeros + 4'(!data[i]);
		end
		return zeros > sdpdi_pkg::DBI_ZERO_LIMIT;
	endfunction : want_invert

	// parity over act, the shared command pins, bank group, bank and address
	assign par_calc = ^{ca.act_n, ca.ras_n_a16, ca.cas_n_a15, ca.we_n_a14,
	                    ca.bg, ca.ba, ca.a};
	assign par_bad  = mode.parity_enable && !cs_n && (par_calc != ca.parity);

	// a command counts only when selected, parity clean and no recovery running
	assign cmd_take = !cs_n && !par_bad && (alert_state != AL_RECOVERY);
	assign opcode   = {ca.ras_n_a16, ca.cas_n_a15, ca.we_n_a14};
	assign is_read  = cmd_take && ca.act_n && (opcode == sdpdi_pkg::OPC_READ);
	assign is_write = cmd_take && ca.act_n && (opcode == sdpdi_pkg::OPC_WRITE);

	// decoded command register, sampled on the rising clock edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmd_valid <= 1'b0;
			cmd       <= '0;
		end else begin
			cmd_valid <= cmd_take;
			if (cmd_take) begin
				cmd.bg <= ca.bg;
				cmd.ba <= ca.ba;
				if (!ca.act_n) begin
					cmd.kind <= sdpdi_pkg::CMD_ACTIVATE;
					cmd.addr <= {opcode, ca.a};
				end else begin
					cmd.kind <= is_read  ? sdpdi_pkg::CMD_READ :
					            is_write ? sdpdi_pkg::CMD_WRITE : sdpdi_pkg::CMD_OTHER;
					cmd.addr <= {3'h0, ca.a};
				end
			end
		end
	end

	// termination follows the sampled termination input unless the mode disables it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			term <= '0;
		end else begin
			term.dq    <= odt && mode.rtt_enable;
			term.dqs_l <= odt && mode.rtt_enable;
			term.dqs_u <= odt && mode.rtt_enable;
			term.dm_l  <= odt && mode.rtt_enable;
			term.dm_u  <= odt && mode.rtt_enable;
		end
	end

	// reference monitor taps on the low data nibble
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			vref_probe_en <= '0;
		end else begin
			vref_probe_en <= mode.vref_monitor ? mode.vref_probe_sel : 4'h0;
		end
	end

	// write strobe edges: either direction counts, but only on a true differential swing
	assign edge_l = (dqs_l_t_in != dqs_l_prev) && (dqs_l_t_in != dqs_l_c_in);
	assign edge_u = (dqs_u_t_in != dqs_u_prev) && (dqs_u_t_in != dqs_u_c_in);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dqs_l_prev      <= 1'b0;
			dqs_u_prev      <= 1'b0;
			upper_hold      <= '0;
			upper_mask_hold <= 1'b1;
		end else begin
			dqs_l_prev <= dqs_l_t_in;
			dqs_u_prev <= dqs_u_t_in;
			// upper lane captured by its own strobe
			if (edge_u) begin
				upper_hold      <= dq_in[15:8];
				upper_mask_hold <= dm_dbi_u_n_in;
			end
		end
	end

	// the lower strobe paces beats; the upper byte is the one its own strobe caught
	assign upper_raw = edge_u ? dq_in[15:8] : upper_hold;
	assign upper_pin = edge_u ? dm_dbi_u_n_in : upper_mask_hold;
	assign data_beat = wr_active && edge_l && (wr_beat <= sdpdi_pkg::BEAT_LAST);
	assign crc_beat  = wr_active && edge_l && (wr_beat == sdpdi_pkg::BEAT_CRC);

	// mask has priority on the shared pin when both functions are set
	always_comb begin
		keep[0] = !(mode.dm_enable && !dm_dbi_l_n_in);
		keep[1] = !(mode.dm_enable && !upper_pin);
		beat_data[7:0]  = dq_in[7:0];
		beat_data[15:8] = upper_raw;
		if (!mode.dm_enable && mode.wdbi_enable) begin
			if (!dm_dbi_l_n_in) begin
				beat_data[7:0] = ~dq_in[7:0];
			end
			if (!upper_pin) begin
				beat_data[15:8] = ~upper_raw;
			end
		end
	end

	assign crc_bad       = crc_beat && ((dq_in[7:0] != crc_l) || (upper_raw != crc_u));
	assign fifo_in_valid = data_beat && (keep != 2'b00);

	// write burst tracking; crc accumulates over the raw lane bytes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_active <= 1'b0;
			wr_beat   <= '0;
			crc_l     <= sdpdi_pkg::CRC_INIT;
			crc_u     <= sdpdi_pkg::CRC_INIT;
		end else if (!wr_active) begin
			wr_active <= is_write;
			wr_beat   <= '0;
			crc_l     <= sdpdi_pkg::CRC_INIT;
			crc_u     <= sdpdi_pkg::CRC_INIT;
		end else if (data_beat) begin
			wr_beat <= wr_beat + 4'h1;
			crc_l   <= crc8_step(crc_l, dq_in[7:0]);
			crc_u   <= crc8_step(crc_u, upper_raw);
			if (wr_beat == sdpdi_pkg::BEAT_LAST && !mode.crc_enable) begin
				wr_active <= 1'b0;
			end
		end else if (crc_beat) begin
			wr_active <= 1'b0;
		end
	end

	// a beat the array side cannot take sets the sticky lost flag; a new loss beats the clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			overrun <= 1'b0;
		end else if (fifo_in_valid && !fifo_in_ready) begin
			overrun <= 1'b1;
		end else if (overrun_clr) begin
			overrun <= 1'b0;
		end
	end

	sdpdi_fifo #(
		.WIDTH (sdpdi_pkg::FIFO_W),
		.DEPTH (sdpdi_pkg::FIFO_DEPTH)
	) u_wr_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_valid  (fifo_in_valid),
		.in_data   ({keep, beat_data}),
		.in_ready  (fifo_in_ready),
		.out_valid (wr_valid),
		.out_data  (wr_word),
		.out_ready (wr_ready)
	);

	// read burst: eight beats from the array, then an optional crc beat
	assign rd_inv_l = mode.rdbi_enable && want_invert(rd_data[7:0]);
	assign rd_inv_u = mode.rdbi_enable && want_invert(rd_data[15:8]);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_req    <= 1'b0;
			rd_active <= 1'b0;
			rd_beat   <= '0;
			rd_crc_l  <= sdpdi_pkg::CRC_INIT;
			rd_crc_u  <= sdpdi_pkg::CRC_INIT;
		end else begin
			rd_req <= is_read && !rd_active;
			if (!rd_active) begin
				rd_active <= is_read;
				rd_beat   <= '0;
				rd_crc_l  <= sdpdi_pkg::CRC_INIT;
				rd_crc_u  <= sdpdi_pkg::CRC_INIT;
			end else if (rd_beat <= sdpdi_pkg::BEAT_LAST) begin
				rd_beat  <= rd_beat + 4'h1;
				rd_crc_l <= crc8_step(rd_crc_l, rd_inv_l ? ~rd_data[7:0] : rd_data[7:0]);
				rd_crc_u <= crc8_step(rd_crc_u, rd_inv_u ? ~rd_data[15:8] : rd_data[15:8]);
				if (rd_beat == sdpdi_pkg::BEAT_LAST && !mode.crc_enable) begin
					rd_active <= 1'b0;
				end
			end else begin
				rd_active <= 1'b0;
			end
		end
	end

	// read pin drive: strobe toggles with every data change, so edges sit on the data
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dq_out         <= '0;
			dq_oe          <= 1'b0;
			dqs_l_t_out    <= 1'b0;
			dqs_l_c_out    <= 1'b1;
			dqs_u_t_out    <= 1'b0;
			dqs_u_c_out    <= 1'b1;
			dqs_oe         <= 1'b0;
			dm_dbi_l_n_out <= sdpdi_pkg::DBI_IDLE;
			dm_dbi_u_n_out <= sdpdi_pkg::DBI_IDLE;
			dm_dbi_oe      <= 1'b0;
		end else if (rd_active) begin
			dq_oe     <= 1'b1;
			dqs_oe    <= 1'b1;
			dm_dbi_oe <= mode.rdbi_enable;
			if (rd_beat <= sdpdi_pkg::BEAT_LAST) begin
				dq_out[7:0]    <= rd_inv_l ? ~rd_data[7:0] : rd_data[7:0];
				dq_out[15:8]   <= rd_inv_u ? ~rd_data[15:8] : rd_data[15:8];
				dm_dbi_l_n_out <= !rd_inv_l;
				dm_dbi_u_n_out <= !rd_inv_u;
			end else begin
				dq_out         <= {rd_crc_u, rd_crc_l};
				dm_dbi_l_n_out <= sdpdi_pkg::DBI_IDLE;
				dm_dbi_u_n_out <= sdpdi_pkg::DBI_IDLE;
			end
			dqs_l_t_out <= !dqs_l_t_out;
			dqs_l_c_out <= dqs_l_t_out;
			dqs_u_t_out <= !dqs_u_t_out;
			dqs_u_c_out <= dqs_u_t_out;
		end else begin
			dq_oe          <= 1'b0;
			dqs_oe         <= 1'b0;
			dm_dbi_oe      <= 1'b0;
			dqs_l_t_out    <= 1'b0;
			dqs_l_c_out    <= 1'b1;
			dqs_u_t_out    <= 1'b0;
			dqs_u_c_out    <= 1'b1;
			dm_dbi_l_n_out <= sdpdi_pkg::DBI_IDLE;
			dm_dbi_u_n_out <= sdpdi_pkg::DBI_IDLE;
		end
	end

	// alert sequencing: parity recovery outranks and replaces a crc pulse; a running recovery is not restarted
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			alert_state <= AL_IDLE;
			alert_cnt   <= '0;
		end else if (par_bad && alert_state != AL_RECOVERY) begin
			alert_state <= AL_RECOVERY;
			alert_cnt   <= sdpdi_pkg::ALERT_CNT_W'(sdpdi_pkg::RECOVERY_CYC - 1);
		end else begin
			case (alert_state)
				AL_IDLE: begin
					if (crc_bad) begin
						alert_state <= AL_CRC_PULSE;
						alert_cnt   <= sdpdi_pkg::ALERT_CNT_W'(sdpdi_pkg::ALERT_CRC_CYC - 1);
					end
				end
				AL_CRC_PULSE, AL_RECOVERY: begin
					if (alert_cnt == '0) begin
						alert_state <= AL_IDLE;
					end else begin
						alert_cnt <= alert_cnt - sdpdi_pkg::ALERT_CNT_W'(1);
					end
				end
				default: begin
					alert_state <= AL_IDLE;
				end
			endcase
		end
	end

	// alert pin and error pulses; in connectivity test the pin is released
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			alert_n_out   <= sdpdi_pkg::ALERT_IDLE;
			alert_oe      <= 1'b0;
			parity_error  <= 1'b0;
			crc_error     <= 1'b0;
			recovery_busy <= 1'b0;
		end else begin
			alert_n_out   <= (alert_state == AL_IDLE);
			alert_oe      <= !mode.conn_test;
			parity_error  <= par_bad && (alert_state != AL_RECOVERY);
			crc_error     <= crc_bad;
			recovery_busy <= (alert_state == AL_RECOVERY);
		end
	end

	// alert as input during connectivity test arrives unclocked, so two stages first
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			alert_sync1    <= 1'b1;
			alert_sync2    <= 1'b1;
			ct_alert_level <= 1'b1;
		end else begin
			alert_sync1    <= alert_n_in;
			alert_sync2    <= alert_sync1;
			ct_alert_level <= mode.conn_test ? alert_sync2 : 1'b1;
		end
	end

endmodule : sdpdi_core

// File: rtl/sdpdi_fifo.sv
// write data fifo with a registered output stage and valid/ready on both sides
module sdpdi_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// filling side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output      logic             in_ready,
	// draining side
	output      logic             out_valid,
	output      logic [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0]   count;
	logic             push;
	logic             pop;

	// storage full blocks the source; the output register is extra room
	assign in_ready = (count != (PTR_W+1)'(DEPTH));
	assign push     = in_valid && in_ready;
	assign pop      = (count != '0) && (!out_valid || out_ready);

	// storage array
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + PTR_W'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + PTR_W'(1);
			end
			count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end

	// output stage keeps the drain side on flip-flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data  <= mem[rd_ptr];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

endmodule : sdpdi_fifo

// File: rtl/sdpdi_pkg.sv
// shared constants, field layouts and carrier types of the pin-level data integrity block
package sdpdi_pkg;

	// data path geometry (sixteen-bit organisation, two byte lanes)
	localparam int DQ_W       = 16;
	localparam int BYTE_W     = 8;
	localparam int LANES      = 2;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_W     = DQ_W + LANES;

	// burst geometry: beats numbered 0..7, the crc beat follows the last one
	localparam logic [3:0] BEAT_LAST = 4'h7;
	localparam logic [3:0] BEAT_CRC  = 4'h8;

	// command pin codes {ras_n, cas_n, we_n} with act_n high
	localparam logic [2:0] OPC_WRITE = 3'h4;
	localparam logic [2:0] OPC_READ  = 3'h5;

	// crc-8 over each byte lane, polynomial x^8+x^2+x+1
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'hFF;

	// read inversion is chosen when more than this many bits of a byte are zero
	localparam logic [3:0] DBI_ZERO_LIMIT = 4'h4;

	// alert timing: times in ns, counts rounded up to whole clock cycles
	localparam int CLK_PERIOD_NS = 20;
	localparam int ALERT_CRC_NS  = 120;
	localparam int RECOVERY_NS   = 400;
	localparam int ALERT_CRC_CYC = (ALERT_CRC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVERY_CYC  = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ALERT_CNT_W   = 8;

	// reset levels of the pins the block drives
	localparam logic ALERT_IDLE = 1'b1;
	localparam logic DBI_IDLE   = 1'b1;

	// decoded command classes
	typedef enum logic [1:0] {
		CMD_ACTIVATE,
		CMD_READ,
		CMD_WRITE,
		CMD_OTHER
	} sdpdi_cmd_kind_t;

	// command/address pins sampled at the clock edge
	typedef struct packed {
		logic        act_n;
		logic        ras_n_a16;
		logic        cas_n_a15;
		logic        we_n_a14;
		logic [1:0]  bg;
		logic [1:0]  ba;
		logic [13:0] a;
		logic        parity;
	} sdpdi_ca_t;

	// mode register settings; the block obeys all except tdqs_enable
	typedef struct packed {
		logic       rtt_enable;     // termination allowed by the mode registers
		logic       parity_enable;  // command/address parity check
		logic       crc_enable;     // crc beat after each burst
		logic       vref_monitor;   // internal reference shown on dq[3:0]
		logic [3:0] vref_probe_sel; // which of dq[3:0] show the reference
		logic       dm_enable;      // shared pin acts as write mask
		logic       wdbi_enable;    // shared pin acts as write inversion
		logic       rdbi_enable;    // shared pin acts as read inversion
		logic       tdqs_enable;    // termination strobe, eight-bit parts only
		logic       conn_test;      // connectivity test mode
	} sdpdi_mode_t;

	// termination switched on per pin group
	typedef struct packed {
		logic dq;
		logic dqs_l;
		logic dqs_u;
		logic dm_l;
		logic dm_u;
	} sdpdi_term_t;

	// command handed to the array side
	typedef struct packed {
		sdpdi_cmd_kind_t kind;
		logic [1:0]      bg;
		logic [1:0]      ba;
		logic [16:0]     addr;
	} sdpdi_cmd_t;

endpackage : sdpdi_pkg
